/* rtl/cmb_pkg.sv */
// shared constants and types for the can message buffer engine
package cmb_pkg;
	// buffer geometry: eight buffers of eight 16-bit words
	localparam int unsigned NUM_BUF = 8;
	localparam int unsigned BUF_IDX_W = 3;
	localparam int unsigned WORDS_PER_BUF = 8;
	localparam int unsigned WORD_IDX_W = 3;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned RAM_DEPTH = 64;
	localparam int unsigned RAM_ADDR_W = 6;
	localparam int unsigned BYTE_ADDR_W = 7;
	localparam logic [3:0] FETCH_LAST = 4'h8;

	// word indices inside one buffer; byte offset is twice the index
	localparam logic [2:0] W_STD_ID = 3'h0;
	localparam logic [2:0] W_EXT_HI = 3'h1;
	localparam logic [2:0] W_EXT_LO_LEN = 3'h2;
	localparam logic [2:0] W_PAY_01 = 3'h3;
	localparam logic [2:0] W_PAY_23 = 3'h4;
	localparam logic [2:0] W_PAY_45 = 3'h5;
	localparam logic [2:0] W_PAY_67 = 3'h6;
	localparam logic [2:0] W_FILTER = 3'h7;

	// field positions
	localparam int unsigned STD_ID_LSB = 2;
	localparam int unsigned STD_ID_MSB = 12;
	localparam int unsigned SUB_REMOTE_BIT = 1;
	localparam int unsigned EXT_FMT_BIT = 0;
	localparam int unsigned EXT_HI_MSB = 11;
	localparam int unsigned EXT_LO_LSB = 10;
	localparam int unsigned REMOTE_BIT = 9;
	localparam int unsigned RSV_HIGH_BIT = 8;
	localparam int unsigned RSV_LOW_BIT = 4;
	localparam int unsigned DLC_MSB = 3;
	localparam int unsigned FILT_LSB = 8;
	localparam int unsigned FILT_MSB = 12;

	// implemented-bit masks; everything outside reads back as zero
	localparam logic [15:0] MASK_STD_ID = 16'h1fff;
	localparam logic [15:0] MASK_EXT_HI = 16'h0fff;
	localparam logic [15:0] MASK_EXT_LO_LEN = 16'hff1f;
	localparam logic [15:0] MASK_PAYLOAD = 16'hffff;
	localparam logic [15:0] MASK_FILTER = 16'h1f00;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// engine states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RX_STORE = 2'b01,
		ST_TX_FETCH = 2'b10,
		ST_TX_SEND = 2'b11
	} cmb_state_t;

	// mask of implemented bits for a word index
	function automatic logic [15:0] word_mask(input logic [2:0] widx);
		logic [15:0] m;
		m = MASK_PAYLOAD;
		case (widx)
			W_STD_ID: m = MASK_STD_ID;
			W_EXT_HI: m = MASK_EXT_HI;
			W_EXT_LO_LEN: m = MASK_EXT_LO_LEN;
			W_FILTER: m = MASK_FILTER;
			default: m = MASK_PAYLOAD;
		endcase
		return m;
	endfunction
endpackage

/* rtl/cmb_msg_ram.sv */
// dual-port message ram holding all buffers, registered read data on both ports
module cmb_msg_ram (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic a_en,
	input wire logic a_we,
	input wire logic [5:0] a_addr,
	input wire logic [15:0] a_wdata,
	output logic [15:0] a_rdata,
	input wire logic b_en,
	input wire logic b_we,
	input wire logic [5:0] b_addr,
	input wire logic [15:0] b_wdata,
	output logic [15:0] b_rdata
);
	// storage; contents are undefined after reset like ordinary ram
	logic [15:0] mem [0:cmb_pkg::RAM_DEPTH-1];

	// writes; on a same-address clash the controller port lands last and wins
	always_ff @(posedge sys_clk) begin
		if (a_en && a_we) begin
			mem[a_addr] <= a_wdata;
		end
		if (b_en && b_we) begin
			mem[b_addr] <= b_wdata;
		end
	end

	// read data registers, one cycle after the enable
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			a_rdata <= cmb_pkg::RESET_WORD;
			b_rdata <= cmb_pkg::RESET_WORD;
		end else begin
			if (a_en) begin
				a_rdata <= mem[a_addr];
			end
			if (b_en) begin
				b_rdata <= mem[b_addr];
			end
		end
	end
endmodule

/* rtl/cmb_engine.sv */
// can message buffer engine: shared message ram, receive store and transmit fetch

// Operation
// - buffer ram is reachable from the dma port
// - word 0: standard id bits 12-2, top zero
// - word 0 bit 1 remote for standard frames
// - word 0 bit 0 selects extended format
// - word 1: extended id 17-6, top zero
// - word 2 bits 15-10: extended id 5-0
// - word 2 bit 9 remote, extended only
// - word 2: length code 3-0, 7-5 unimplemented
// - words 3-6 carry payload, even byte low
// - word 7 bits 12-8 hold matching filter
// - filter field written only for receive buffers
// - setting send request clears outcome flags
// - report aborted, arbitration lost, bus error
// - request self-clears on success; clear aborts
module cmb_engine (
	input wire logic sys_clk,
	input wire logic rstn,
	// dma / cpu port into message ram, byte addressed
	input wire logic dma_en,
	input wire logic dma_we,
	input wire logic [6:0] dma_addr,
	input wire logic [15:0] dma_wdata,
	output logic [15:0] dma_rdata,
	// received frame from the protocol engine
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [2:0] rx_buf,
	input wire logic [10:0] rx_std_id,
	input wire logic rx_ext,
	input wire logic rx_remote,
	input wire logic [17:0] rx_ext_id,
	input wire logic [3:0] rx_dlc,
	input wire logic [63:0] rx_data,
	input wire logic [4:0] rx_filter,
	// software send request control
	input wire logic tx_req_set,
	input wire logic tx_req_clr,
	input wire logic [2:0] tx_req_idx,
	output logic [7:0] send_request,
	output logic [7:0] send_aborted_flag,
	output logic [7:0] arbitration_lost_flag,
	output logic [7:0] send_bus_error_flag,
	// frame handed to the protocol engine
	output logic tx_frame_valid,
	output logic tx_abort_req,
	output logic [2:0] tx_buf,
	output logic [10:0] tx_std_id,
	output logic extended_format_flag,
	output logic tx_remote,
	output logic [17:0] tx_ext_id,
	output logic [3:0] tx_dlc,
	output logic [63:0] tx_data,
	input wire logic tx_done_ok,
	input wire logic tx_lost_arb,
	input wire logic tx_bus_err,
	input wire logic tx_aborted
);
	cmb_pkg::cmb_state_t state_ff; // engine state
	cmb_pkg::cmb_state_t nxt_state;
	logic [3:0] cnt_ff; // word counter for store and fetch
	logic [2:0] cur_ff; // buffer being stored or sent
	logic abort_pend_ff; // software cleared the request in flight
	logic rd_vld_ff; // controller read data arrives this cycle
	logic [2:0] rd_word_ff; // word index of that read data
	logic [15:0] tx_w_ff [0:7]; // fetched transmit buffer image
	logic [15:0] rx_w_ff [0:7]; // receive buffer image awaiting store
	logic ctl_en; // controller ram port
	logic ctl_we;
	logic [5:0] ctl_addr;
	logic [15:0] ctl_wdata;
	logic [15:0] ctl_rdata;
	logic [15:0] dma_wmasked; // dma write with unimplemented bits forced low
	logic [2:0] dma_word; // word index inside a buffer
	logic [2:0] tx_sel; // lowest pending buffer
	logic tx_any; // some buffer requests sending
	logic fetch_done;
	logic evt_ok, evt_arb, evt_err, evt_abt; // outcome events for cur_ff

	// byte offset 2n selects word n; bit 0 of the byte address is dropped
	assign dma_word = dma_addr[3:1];
	// unimplemented bits are never stored, so they always read zero
	assign dma_wmasked = dma_wdata & cmb_pkg::word_mask(dma_word);

	// shared ram: dma port on a, controller on b
	cmb_msg_ram u_ram (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.a_en(dma_en),
		.a_we(dma_we),
		.a_addr(dma_addr[6:1]),
		.a_wdata(dma_wmasked),
		.a_rdata(dma_rdata),
		.b_en(ctl_en),
		.b_we(ctl_we),
		.b_addr(ctl_addr),
		.b_wdata(ctl_wdata),
		.b_rdata(ctl_rdata)
	);

	// lowest-numbered pending buffer goes first
	always_comb begin
		tx_sel = 3'h0;
		tx_any = 1'b0;
		for (int i = cmb_pkg::NUM_BUF - 1; i >= 0; i--) begin
			if (send_request[i]) begin
				tx_sel = 3'(i);
				tx_any = 1'b1;
			end
		end
	end

	// handshakes and outcome events
	assign rx_ready = (state_ff == cmb_pkg::ST_IDLE);
	assign fetch_done = (state_ff == cmb_pkg::ST_TX_FETCH) && (cnt_ff == cmb_pkg::FETCH_LAST);
	assign tx_frame_valid = (state_ff == cmb_pkg::ST_TX_SEND);
	assign tx_abort_req = tx_frame_valid && abort_pend_ff;
	assign evt_ok = tx_frame_valid && tx_done_ok;
	assign evt_arb = tx_frame_valid && tx_lost_arb;
	assign evt_err = tx_frame_valid && tx_bus_err;
	// an abort raised while still fetching ends the attempt before it reaches the bus
	assign evt_abt = (tx_frame_valid && tx_aborted) || (fetch_done && abort_pend_ff);

	// controller port: store words while receiving, read words while fetching
	always_comb begin
		ctl_en = 1'b0;
		ctl_we = 1'b0;
		ctl_addr = {cur_ff, cnt_ff[2:0]};
		ctl_wdata = rx_w_ff[cnt_ff[2:0]];
		if (state_ff == cmb_pkg::ST_RX_STORE) begin
			ctl_en = 1'b1;
			ctl_we = 1'b1;
		end else if (state_ff == cmb_pkg::ST_TX_FETCH && !cnt_ff[3]) begin
			ctl_en = 1'b1;
		end
	end

	// next state; a waiting receive beats a transmit because the sender will not wait
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cmb_pkg::ST_IDLE: begin
				if (rx_valid) begin
					nxt_state = cmb_pkg::ST_RX_STORE;
				end else if (tx_any) begin
					nxt_state = cmb_pkg::ST_TX_FETCH;
				end
			end
			cmb_pkg::ST_RX_STORE: begin
				if (cnt_ff[2:0] == 3'h7) begin
					nxt_state = cmb_pkg::ST_IDLE;
				end
			end
			cmb_pkg::ST_TX_FETCH: begin
				if (fetch_done) begin
					nxt_state = abort_pend_ff ? cmb_pkg::ST_IDLE : cmb_pkg::ST_TX_SEND;
				end
			end
			cmb_pkg::ST_TX_SEND: begin
				// lost arbitration or bus error leave the request up for a retry
				if (evt_ok || evt_arb || evt_err || evt_abt) begin
					nxt_state = cmb_pkg::ST_IDLE;
				end
			end
			default: nxt_state = cmb_pkg::ST_IDLE;
		endcase
	end

	// state, counter and selected buffer
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_ff <= cmb_pkg::ST_IDLE;
			cnt_ff <= 4'h0;
			cur_ff <= 3'h0;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == cmb_pkg::ST_IDLE) begin
				cnt_ff <= 4'h0;
				cur_ff <= rx_valid ? rx_buf : tx_sel;
			end else if (state_ff != cmb_pkg::ST_TX_SEND && !fetch_done) begin
				cnt_ff <= cnt_ff + 4'h1;
			end
		end
	end

	// abort request for the buffer in flight, dropped when the engine goes idle
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			abort_pend_ff <= 1'b0;
		end else if (nxt_state == cmb_pkg::ST_IDLE) begin
			abort_pend_ff <= 1'b0;
		end else if (tx_req_clr && tx_req_idx == cur_ff && send_request[cur_ff]
			&& (state_ff == cmb_pkg::ST_TX_FETCH || state_ff == cmb_pkg::ST_TX_SEND)) begin
			abort_pend_ff <= 1'b1;
		end
	end

	// receive image is built at acceptance so the store is a plain word walk
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			for (int k = 0; k < cmb_pkg::WORDS_PER_BUF; k++) begin
				rx_w_ff[k] <= cmb_pkg::RESET_WORD;
			end
		end else if (rx_valid && rx_ready) begin
			// extended frames carry a recessive substitute bit, standard ones the remote bit
			rx_w_ff[cmb_pkg::W_STD_ID] <= {3'h0, rx_std_id, rx_ext | rx_remote, rx_ext};
			rx_w_ff[cmb_pkg::W_EXT_HI] <= {4'h0, rx_ext_id[17:6]};
			// reserved bits stored as zero, remote bit only meaningful when extended
			rx_w_ff[cmb_pkg::W_EXT_LO_LEN] <= {rx_ext_id[5:0], rx_ext & rx_remote, 1'b0,
				3'h0, 1'b0, rx_dlc};
			rx_w_ff[cmb_pkg::W_PAY_01] <= rx_data[15:0];
			rx_w_ff[cmb_pkg::W_PAY_23] <= rx_data[31:16];
			rx_w_ff[cmb_pkg::W_PAY_45] <= rx_data[47:32];
			rx_w_ff[cmb_pkg::W_PAY_67] <= rx_data[63:48];
			rx_w_ff[cmb_pkg::W_FILTER] <= {3'h0, rx_filter, 8'h00};
		end
	end

	// fetch pipeline: ram answers one cycle after the read
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rd_vld_ff <= 1'b0;
			rd_word_ff <= 3'h0;
		end else begin
			rd_vld_ff <= (state_ff == cmb_pkg::ST_TX_FETCH) && !cnt_ff[3];
			rd_word_ff <= cnt_ff[2:0];
		end
	end

	// transmit image capture
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			for (int k = 0; k < cmb_pkg::WORDS_PER_BUF; k++) begin
				tx_w_ff[k] <= cmb_pkg::RESET_WORD;
			end
		end else if (rd_vld_ff) begin
			tx_w_ff[rd_word_ff] <= ctl_rdata;
		end
	end

	// frame fields decoded from the captured words; word 7 is never consulted
	assign tx_buf = cur_ff;
	assign tx_std_id = tx_w_ff[cmb_pkg::W_STD_ID][cmb_pkg::STD_ID_MSB:cmb_pkg::STD_ID_LSB];
	assign extended_format_flag = tx_w_ff[cmb_pkg::W_STD_ID][cmb_pkg::EXT_FMT_BIT];
	// remote bit source depends on the format; the other one is ignored
	assign tx_remote = extended_format_flag ?
		tx_w_ff[cmb_pkg::W_EXT_LO_LEN][cmb_pkg::REMOTE_BIT] :
		tx_w_ff[cmb_pkg::W_STD_ID][cmb_pkg::SUB_REMOTE_BIT];
	assign tx_ext_id = {tx_w_ff[cmb_pkg::W_EXT_HI][cmb_pkg::EXT_HI_MSB:0],
		tx_w_ff[cmb_pkg::W_EXT_LO_LEN][15:cmb_pkg::EXT_LO_LSB]};
	assign tx_dlc = tx_w_ff[cmb_pkg::W_EXT_LO_LEN][cmb_pkg::DLC_MSB:0];
	assign tx_data = {tx_w_ff[cmb_pkg::W_PAY_67], tx_w_ff[cmb_pkg::W_PAY_45],
		tx_w_ff[cmb_pkg::W_PAY_23], tx_w_ff[cmb_pkg::W_PAY_01]};

	// per-buffer request and outcome flags; an outcome beats a same-cycle request set in the outcome flags, but the set wins in the request
	for (genvar i = 0; i < cmb_pkg::NUM_BUF; i++) begin : g_buf
		logic hit; // this buffer is the one in the engine
		logic sw_set;
		logic sw_clr;
		logic busy; // fetching or on the bus
		assign hit = (cur_ff == 3'(i));
		assign sw_set = tx_req_set && (tx_req_idx == 3'(i));
		assign sw_clr = tx_req_clr && (tx_req_idx == 3'(i));
		assign busy = hit && (state_ff == cmb_pkg::ST_TX_FETCH || state_ff == cmb_pkg::ST_TX_SEND);

		// send request
		always_ff @(posedge sys_clk) begin
			if (!rstn) begin
				send_request[i] <= 1'b0;
			end else if (sw_set) begin
				send_request[i] <= 1'b1;
			end else if (sw_clr || (hit && (evt_ok || evt_abt))) begin
				send_request[i] <= 1'b0;
			end
		end

		// outcome flags
		always_ff @(posedge sys_clk) begin
			if (!rstn) begin
				send_aborted_flag[i] <= 1'b0;
				arbitration_lost_flag[i] <= 1'b0;
				send_bus_error_flag[i] <= 1'b0;
			end else begin
				// an idle request cleared by software is aborted at once
				if ((sw_clr && !sw_set && send_request[i] && !busy) || (hit && evt_abt)) begin
					send_aborted_flag[i] <= 1'b1;
				end else if (sw_set) begin
					send_aborted_flag[i] <= 1'b0;
				end
				if (hit && evt_arb) begin
					arbitration_lost_flag[i] <= 1'b1;
				end else if (sw_set) begin
					arbitration_lost_flag[i] <= 1'b0;
				end
				if (hit && evt_err) begin
					send_bus_error_flag[i] <= 1'b1;
				end else if (sw_set) begin
					send_bus_error_flag[i] <= 1'b0;
				end
			end
		end
	end

	// checks
	chk_rx_store_walk: assert property (@(posedge sys_clk) disable iff (!rstn)
		(rx_valid && rx_ready) |=> ctl_we [*8] ##1 rx_ready)
		else $error("receive store is not eight consecutive words");
	chk_word0_top_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		(ctl_we && ctl_addr[2:0] == cmb_pkg::W_STD_ID) |-> ctl_wdata[15:13] == 3'h0)
		else $error("word 0 unimplemented bits written nonzero");
	chk_word1_top_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		(ctl_we && ctl_addr[2:0] == cmb_pkg::W_EXT_HI) |-> ctl_wdata[15:12] == 4'h0)
		else $error("word 1 unimplemented bits written nonzero");
	chk_word2_gaps: assert property (@(posedge sys_clk) disable iff (!rstn)
		(ctl_we && ctl_addr[2:0] == cmb_pkg::W_EXT_LO_LEN) |-> ctl_wdata[8:4] == 5'h00)
		else $error("word 2 reserved or unimplemented bits nonzero");
	chk_filter_code: assert property (@(posedge sys_clk) disable iff (!rstn)
		(rx_valid && rx_ready) |-> ##8 (ctl_we && ctl_addr[2:0] == cmb_pkg::W_FILTER
		&& ctl_wdata == {3'h0, $past(rx_filter, 8), 8'h00}))
		else $error("filter code not stored in word 7");
	chk_set_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
		(tx_req_set && !evt_abt && !evt_arb && !evt_err) |=>
		!send_aborted_flag[$past(tx_req_idx)] && !arbitration_lost_flag[$past(tx_req_idx)]
		&& !send_bus_error_flag[$past(tx_req_idx)])
		else $error("outcome flags survive a new request");
	chk_arb_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
		evt_arb |=> arbitration_lost_flag[$past(cur_ff)] && rx_ready)
		else $error("lost arbitration not reported");
	chk_ok_clears_req: assert property (@(posedge sys_clk) disable iff (!rstn)
		(evt_ok && !(tx_req_set && tx_req_idx == cur_ff)) |=> !send_request[$past(cur_ff)])
		else $error("request not cleared after success");
	chk_fetch_time: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(state_ff == cmb_pkg::ST_TX_FETCH) |-> ##8 fetch_done)
		else $error("fetch did not finish in nine cycles");
	cov_rx_store: cover property (@(posedge sys_clk) disable iff (!rstn)
		rx_valid && rx_ready && rx_ext);
	cov_tx_ok: cover property (@(posedge sys_clk) disable iff (!rstn) evt_ok);
	cov_tx_abort: cover property (@(posedge sys_clk) disable iff (!rstn) tx_abort_req ##1 evt_abt);
endmodule

/* verif/cmb_tx_partner.sv */
// protocol engine model on the transmit side, answering offered frames
module cmb_tx_partner (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic tx_frame_valid,
	input wire logic tx_abort_req,
	input wire logic [1:0] outcome,
	input wire logic [3:0] delay,
	output logic tx_done_ok,
	output logic tx_lost_arb,
	output logic tx_bus_err,
	output logic tx_aborted
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_ff; // cycles the current frame has been offered
	logic [3:0] ev_ff; // one-hot outcome pulse: ok, lost arbitration, bus error, aborted

	// one pulse per offer, once the commanded delay has run out
	always_ff @(posedge sys_clk) begin
		if (!rstn || !tx_frame_valid) begin
			cnt_ff <= 5'h00;
			ev_ff <= 4'h0;
		end else begin
			cnt_ff <= cnt_ff + 5'h01;
			ev_ff <= 4'h0;
			if (cnt_ff == {1'b0, delay}) begin
				// a pending abort request wins over the commanded outcome
				ev_ff <= tx_abort_req ? 4'h8 : 4'h1 << outcome;
			end
		end
	end

	// pulses leave only while a frame is offered, never outside it
	assign tx_done_ok = ev_ff[0];
	assign tx_lost_arb = ev_ff[1];
	assign tx_bus_err = ev_ff[2];
	assign tx_aborted = ev_ff[3];
endmodule

/* verif/test_can_message_buffer_format.sv */
// self-checking bench for the can message buffer engine
module test_can_message_buffer_format;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, rstn, dma_en, dma_we, rx_valid, rx_ready, rx_ext, rx_remote;
	logic [6:0] dma_addr; // byte address into message ram
	logic [15:0] dma_wdata, dma_rdata;
	logic [2:0] rx_buf, tx_req_idx, tx_buf;
	logic [10:0] rx_std_id, tx_std_id;
	logic [17:0] rx_ext_id, tx_ext_id;
	logic [3:0] rx_dlc, tx_dlc, delay;
	logic [63:0] rx_data, tx_data;
	logic [4:0] rx_filter;
	logic tx_req_set, tx_req_clr, tx_frame_valid, tx_abort_req, extended_format_flag, tx_remote;
	logic [7:0] send_request, send_aborted_flag, arbitration_lost_flag, send_bus_error_flag;
	logic tx_done_ok, tx_lost_arb, tx_bus_err, tx_aborted;
	logic [1:0] outcome; // answer the partner gives to the next offer
	logic [15:0] seed, v, d, rd; // random state, draws and last read word
	logic [15:0] w [8]; // image of the transmit buffer as software wrote it
	int errors = 0;
	int tests_run = 0;

	cmb_engine i_dut (.sys_clk, .rstn, .dma_en, .dma_we, .dma_addr, .dma_wdata, .dma_rdata,
		.rx_valid, .rx_ready, .rx_buf, .rx_std_id, .rx_ext, .rx_remote, .rx_ext_id, .rx_dlc,
		.rx_data, .rx_filter, .tx_req_set, .tx_req_clr, .tx_req_idx, .send_request,
		.send_aborted_flag, .arbitration_lost_flag, .send_bus_error_flag, .tx_frame_valid,
		.tx_abort_req, .tx_buf, .tx_std_id, .extended_format_flag, .tx_remote, .tx_ext_id,
		.tx_dlc, .tx_data, .tx_done_ok, .tx_lost_arb, .tx_bus_err, .tx_aborted);

	cmb_tx_partner i_partner (.sys_clk, .rstn, .tx_frame_valid, .tx_abort_req, .outcome,
		.delay, .tx_done_ok, .tx_lost_arb, .tx_bus_err, .tx_aborted);

	// 25 mhz system clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// verdict and end of run, shared by the main sequence and the watchdog
	task automatic results();
		if (errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// compare a ram word
	task automatic chkw(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// compare a port field or flag group
	task automatic chkf(input string nm, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// fibonacci lfsr step, fixed start for a repeatable run
	function automatic void rnd(output logic [15:0] r);
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		r = seed;
	endfunction

	// one ram access; read data is registered, so it is taken a cycle later
	task automatic dma(input logic we, input logic [2:0] b, input logic [2:0] wi,
		input logic [15:0] dt);
		@(negedge sys_clk);
		dma_en = 1'b1;
		dma_we = we;
		dma_addr = {b, wi, 1'b0}; // word n of a buffer sits at byte 2n
		dma_wdata = dt;
		@(negedge sys_clk);
		rd = dma_rdata;
		dma_en = 1'b0;
	endtask

	// one-cycle software pulse on the send request of buffer b
	task automatic req(input logic clr, input logic [2:0] b);
		@(negedge sys_clk);
		tx_req_set = !clr;
		tx_req_clr = clr;
		tx_req_idx = b;
		@(negedge sys_clk);
		tx_req_set = 1'b0;
		tx_req_clr = 1'b0;
	endtask

	// bounded wait for the offer level, so a stuck engine cannot hang the run
	task automatic wait_tx(input logic lvl);
		int n;
		n = 0;
		while (tx_frame_valid !== lvl && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		chkf("tx_frame_valid", 64'(lvl), 64'(tx_frame_valid));
	endtask

	// implemented bits of each buffer word; the rest must read zero
	function automatic logic [15:0] msk(input int i);
		case (i)
			0: return 16'h1fff;
			1: return 16'h0fff;
			2: return 16'hff1f;
			7: return 16'h1f00;
			default: return 16'hffff;
		endcase
	endfunction

	// word a received frame must leave in ram
	function automatic logic [15:0] rxw(input int i);
		case (i)
			0: return {3'h0, rx_std_id, rx_ext | rx_remote, rx_ext};
			1: return {4'h0, rx_ext_id[17:6]};
			2: return {rx_ext_id[5:0], rx_ext & rx_remote, 5'h00, rx_dlc};
			7: return {3'h0, rx_filter, 8'h00};
			default: return rx_data[16 * (i - 3) +: 16];
		endcase
	endfunction

	// offered frame must match the buffer image of buffer 5
	task automatic chk_tx();
		chkf("tx_buf", 64'h5, 64'(tx_buf));
		chkf("tx_std_id", 64'(w[0][12:2]), 64'(tx_std_id));
		chkf("ext flag", 64'(w[0][0]), 64'(extended_format_flag));
		chkf("tx_remote", 64'(w[0][0] ? w[2][9] : w[0][1]), 64'(tx_remote));
		chkf("tx_ext_id", 64'({w[1][11:0], w[2][15:10]}), 64'(tx_ext_id));
		chkf("tx_dlc", 64'(w[2][3:0]), 64'(tx_dlc));
		chkf("tx_data", {w[6], w[5], w[4], w[3]}, tx_data);
	endtask

	// watchdog: the sequence needs under 400 cycles, the limit is 20000
	initial begin
		#(40 * 20000);
		errors++;
		$display("BAD watchdog expected done seen hang");
		results();
	end

	// main sequence
	initial begin
		seed = 16'hb0b5;
		{dma_en, dma_we, dma_addr, dma_wdata, rx_valid, rx_buf, rx_std_id} = '0;
		{rx_ext, rx_remote, rx_ext_id, rx_dlc, rx_data, rx_filter} = '0;
		{tx_req_set, tx_req_clr, tx_req_idx, outcome, delay} = '0;
		rstn = 1'b0;
		repeat (20) @(negedge sys_clk);
		rstn = 1'b1;
		chkf("flags", 64'h0, 64'({send_request, send_aborted_flag, arbitration_lost_flag,
			send_bus_error_flag, tx_frame_valid}));
		chkf("rx_ready", 64'h1, 64'(rx_ready));
		// software places words anywhere in the area: unimplemented bits drop
		for (int k = 0; k < 24; k++) begin
			rnd(v);
			rnd(d);
			if (k < 8) begin
				v[5:3] = k[2:0];
				d = 16'hffff;
			end
			dma(1'b1, v[2:0], v[5:3], d);
			dma(1'b0, v[2:0], v[5:3], 16'h0000);
			chkw("dma word", d & msk(int'(v[5:3])), rd);
		end
		// received frames in every format and remote combination
		for (int k = 0; k < 4; k++) begin
			rnd(v);
			rnd(d);
			@(negedge sys_clk);
			rx_valid = 1'b1;
			rx_buf = v[2:0];
			rx_ext = k[0];
			rx_remote = k[1];
			rx_std_id = v[15:5];
			rx_ext_id = {d, v[1:0]};
			rx_dlc = d[3:0];
			rx_data = {d, v, ~d, ~v};
			rx_filter = d[15:11];
			@(negedge sys_clk);
			rx_valid = 1'b0;
			chkf("rx_ready busy", 64'h0, 64'(rx_ready));
			repeat (8) @(negedge sys_clk);
			chkf("rx_ready back", 64'h1, 64'(rx_ready));
			for (int i = 0; i < 8; i++) begin
				dma(1'b0, rx_buf, i[2:0], 16'h0000);
				chkw("rx word", rxw(i), rd);
			end
		end
		// fill transmit buffer 5; reserved bits 8 and 4 stay zero
		for (int i = 0; i < 8; i++) begin
			rnd(d);
			w[i] = d & msk(i) & (i == 2 ? 16'hfeef : 16'hffff);
			dma(1'b1, 3'h5, i[2:0], w[i]);
		end
		// lost arbitration then bus error, each retried and then sent cleanly
		for (int o = 1; o < 3; o++) begin
			w[0][0] = o[0];
			dma(1'b1, 3'h5, 3'h0, w[0]);
			outcome = o[1:0];
			req(1'b0, 3'h5);
			chkf("flags after set", 64'h0, 64'({send_aborted_flag[5], arbitration_lost_flag[5],
				send_bus_error_flag[5]}));
			wait_tx(1'b1);
			chk_tx();
			wait_tx(1'b0);
			chkf("outcome flags", 64'(o == 1 ? 3'b010 : 3'b001), 64'({send_aborted_flag[5],
				arbitration_lost_flag[5], send_bus_error_flag[5]}));
			chkf("request kept", 64'h1, 64'(send_request[5]));
			outcome = 2'h0;
			wait_tx(1'b1);
			wait_tx(1'b0);
			chkf("request after ok", 64'h0, 64'(send_request[5]));
		end
		dma(1'b0, 3'h5, 3'h7, 16'h0000);
		chkw("word7 kept", w[7], rd);
		// slow partner: abort one request idle, another while offered
		delay = 4'hf;
		req(1'b0, 3'h5);
		wait_tx(1'b1);
		req(1'b0, 3'h6);
		req(1'b1, 3'h6);
		chkf("idle abort", 64'h1, 64'({send_request[6], send_aborted_flag[6]}));
		req(1'b1, 3'h5);
		chkf("abort offered", 64'h1, 64'(tx_abort_req));
		wait_tx(1'b0);
		chkf("abort flags", 64'h1, 64'({send_request[5], send_aborted_flag[5]}));
		results();
	end
endmodule
